// ### src/fbadp_pkg.sv
// fbadp_pkg: constants, modes and carrier types of the flash bus port.
// assumes a 16-bit word-wide flash of the largest (dual-die) density.
package fbadp_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_MSB = 25; // top word-address pin
  localparam int ADDR_LSB = 1; // least significant pin, word step
  localparam int DATA_W = 16;
  localparam int DIE_SEL_BIT = 25; // die_select_address_bit
  localparam int WAIT_POL_BIT = 10; // wait_polarity_bit position

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [ADDR_MSB:ADDR_LSB] fbadp_addr_t;
  typedef logic [DATA_W-1:0] fbadp_data_t;

  // read source chosen by the current read mode
  typedef enum logic [1:0] {
    FBADP_READ_ARRAY,
    FBADP_READ_STATUS,
    FBADP_READ_PROTECTION,
    FBADP_READ_CONFIG
  } fbadp_read_mode_e;

  // raw bus pins as seen by the device
  typedef struct packed {
    fbadp_addr_t addr;
    fbadp_data_t dq;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_strobe_n;
    logic bus_clk;
  } fbadp_pins_s;

  // idle pin image used while reset holds the synchroniser
  localparam fbadp_pins_s PINS_IDLE = '{
    addr: '0,
    dq: '0,
    ce_n: 1'b1,
    oe_n: 1'b1,
    we_n: 1'b1,
    address_strobe_n: 1'b1,
    bus_clk: 1'b0
  };

  localparam fbadp_addr_t ADDR_RESET = '0;
  localparam fbadp_data_t DATA_RESET = '0;

endpackage

// ### src/fbadp_port.sv
// fbadp_port: device-side address/data bus port of a parallel flash.
// assumes pins arrive asynchronously and are sampled on clock_in; the
// core behind it supplies read data, read mode and sync-mode flag.
//
// Behaviour
// - address bus 25:1 for densest part
// - bit one is word-step least significant
// - top address bit picks upper die
// - write commands and data latched internally
// - read mux by current read mode
// - data floats when chip or output off
// - sync capture at strobe rise or clock
// - async strobe low flows, rise latches
// - chip select low activates die logic
// - deselect gives standby, floats data, wait
// - bus clock used only in sync reads
// - output buffers on only with output low
// - sync wait asserted for invalid data
// - wait deasserted in async and writes
// - write captured on write strobe rise
`timescale 1ns/1ns
module fbadp_port
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire fbadp_pkg::fbadp_pins_s pins_in,
  input wire logic sync_mode_in,
  input wire fbadp_pkg::fbadp_read_mode_e read_mode_in,
  input wire fbadp_pkg::fbadp_data_t array_data_in,
  input wire fbadp_pkg::fbadp_data_t status_in,
  input wire fbadp_pkg::fbadp_data_t protection_in,
  input wire fbadp_pkg::fbadp_data_t read_config_register_in,
  input wire logic data_valid_in,
  output fbadp_pkg::fbadp_data_t dq_out,
  output logic dq_oe_out,
  output logic wait_out,
  output logic wait_oe_out,
  output fbadp_pkg::fbadp_addr_t read_addr_out,
  output logic die_upper_out,
  output logic die_active_out,
  output logic standby_out,
  output logic write_strobe_out,
  output fbadp_pkg::fbadp_addr_t write_addr_out,
  output fbadp_pkg::fbadp_data_t write_data_out
);
  import fbadp_pkg::*;

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta, rst_sync_n;
  fbadp_pins_s pins_meta, pins, pins_prev;

  // reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // two-flop pin sampling plus one history stage for edges
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pins_meta <= PINS_IDLE;
      pins <= PINS_IDLE;
      pins_prev <= PINS_IDLE;
    end
    else
    begin
      pins_meta <= pins_in;
      pins <= pins_meta;
      pins_prev <= pins;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic captured;
  fbadp_data_t read_word;
  wire strobe_low = !pins.address_strobe_n;
  wire strobe_rise = pins.address_strobe_n && !pins_prev.address_strobe_n;
  wire clk_rise = pins.bus_clk && !pins_prev.bus_clk;
  wire we_rise = pins.we_n && !pins_prev.we_n;
  wire chip_on = !pins.ce_n;
  wire drive_on = chip_on && !pins.oe_n;
  wire wait_pol = read_config_register_in[WAIT_POL_BIT];
  wire sync_clk_cap = sync_mode_in && strobe_low && clk_rise && !captured;
  wire sync_cap = sync_clk_cap || (sync_mode_in && strobe_rise && !captured);
  // flow while low, latch at rise
  wire async_cap = !sync_mode_in && (strobe_low || strobe_rise);
  wire addr_load = sync_cap || async_cap;
  wire wait_active = sync_mode_in && !data_valid_in && pins.we_n;

  assign read_word = (read_mode_in == FBADP_READ_STATUS) ? status_in :
    (read_mode_in == FBADP_READ_PROTECTION) ? protection_in :
    (read_mode_in == FBADP_READ_CONFIG) ? read_config_register_in :
    array_data_in;

  // ----------------------------------------------------------------
  // address latch
  // ----------------------------------------------------------------
  // capture flag blocks later clock edges until the strobe goes high
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      captured <= 1'b0;
    else if (!strobe_low)
      captured <= 1'b0;
    else if (sync_clk_cap)
      captured <= 1'b1;
  end

  // word address latch, bit one lowest
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      read_addr_out <= ADDR_RESET;
    else if (addr_load)
      read_addr_out <= pins.addr;
  end

  // die chosen by top address bit
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      die_upper_out <= 1'b0;
    else
      die_upper_out <= read_addr_out[DIE_SEL_BIT];
  end

  // ----------------------------------------------------------------
  // chip select, output drive and wait
  // ----------------------------------------------------------------
  // chip select activates, deselect idles
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      die_active_out <= 1'b0;
      standby_out <= 1'b1;
    end
    else
    begin
      die_active_out <= chip_on;
      standby_out <= !chip_on;
    end
  end

  // drive only with chip and output on
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dq_oe_out <= 1'b0;
      wait_oe_out <= 1'b0;
      dq_out <= DATA_RESET;
      wait_out <= 1'b0;
    end
    else
    begin
      dq_oe_out <= drive_on;
      wait_oe_out <= drive_on;
      dq_out <= read_word;
      wait_out <= wait_active ? wait_pol : !wait_pol;
    end
  end

  // ----------------------------------------------------------------
  // write capture
  // ----------------------------------------------------------------
  // latch address and data at strobe rise
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      write_strobe_out <= 1'b0;
      write_addr_out <= ADDR_RESET;
      write_data_out <= DATA_RESET;
    end
    else
    begin
      write_strobe_out <= we_rise && chip_on;
      if (we_rise && chip_on)
      begin
        write_addr_out <= pins.addr;
        write_data_out <= pins.dq;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_sync_n);

  sequence s_drive_req;
    !pins.ce_n && !pins.oe_n;
  endsequence
  sequence s_sync_clk;
    sync_mode_in && !pins.address_strobe_n && clk_rise && !captured;
  endsequence

  property p_float_off;
    !(!pins.ce_n && !pins.oe_n) |=> !dq_oe_out && !wait_oe_out;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("data or wait driven while deselected");
  property p_drive_on;
    s_drive_req |=> dq_oe_out ##0 dq_out == $past(read_word);
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("output not driven with chip and output on");
  property p_standby;
    pins.ce_n |=> standby_out && !die_active_out && !wait_oe_out;
  endproperty
  a_standby: assert property (p_standby)
    else $error("deselect did not give standby");
  property p_active;
    !pins.ce_n |=> die_active_out && !standby_out;
  endproperty
  a_active: assert property (p_active)
    else $error("chip select did not activate die");
  property p_async_flow;
    !sync_mode_in && strobe_low |=> read_addr_out == $past(pins.addr);
  endproperty
  a_async_flow: assert property (p_async_flow)
    else $error("address not flowing with strobe low");
  property p_async_hold;
    !sync_mode_in && pins.address_strobe_n && pins_prev.address_strobe_n
      |=> $stable(read_addr_out);
  endproperty
  a_async_hold: assert property (p_async_hold)
    else $error("address changed with strobe held high");
  property p_sync_clk_cap;
    s_sync_clk |=> read_addr_out == $past(pins.addr) && captured;
  endproperty
  a_sync_clk_cap: assert property (p_sync_clk_cap)
    else $error("sync address not captured on clock edge");
  property p_sync_once;
    sync_mode_in && captured && !pins.address_strobe_n
      |=> $stable(read_addr_out);
  endproperty
  a_sync_once: assert property (p_sync_once)
    else $error("sync address recaptured after first edge");
  property p_die_sel;
    1'b1 |=> die_upper_out == $past(read_addr_out[DIE_SEL_BIT]);
  endproperty
  a_die_sel: assert property (p_die_sel)
    else $error("die select does not follow top address bit");
  property p_write_cap;
    we_rise && !pins.ce_n |=> write_strobe_out
      && write_data_out == $past(pins.dq)
      && write_addr_out == $past(pins.addr) ##1 !write_strobe_out;
  endproperty
  a_write_cap: assert property (p_write_cap)
    else $error("write not captured on write strobe rise");
  property p_wait_off;
    rst_sync_n && (!sync_mode_in || !pins.we_n) // skip reset exit
      |=> wait_out == !$past(wait_pol);
  endproperty
  a_wait_off: assert property (p_wait_off)
    else $error("wait asserted outside sync reads");
  property p_wait_on;
    sync_mode_in && !data_valid_in && pins.we_n
      |=> wait_out == $past(wait_pol);
  endproperty
  a_wait_on: assert property (p_wait_on)
    else $error("wait not asserted for invalid sync data");
  property p_status_read;
    read_mode_in == FBADP_READ_STATUS |=> dq_out == $past(status_in);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status not selected in status read mode");

endmodule // fbadp_port

// ### bench/fbadp_host_model.sv
// fbadp_host_model: behavioural host controller driving the flash pins.
// assumes one clock shared with the port; pins change just after an edge.
`timescale 1ns/1ns
module fbadp_host_model
(
  input wire logic clock_in,
  output fbadp_pkg::fbadp_pins_s pins_out
);
  import fbadp_pkg::*;

  // ----------------------------------------------------------------
  // pin drive tasks
  // ----------------------------------------------------------------
  // chip idle, bus clock parked
  initial
  begin
    pins_out = PINS_IDLE;
  end

  // wait a number of rising edges
  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // control strobes for a read or an idle bus
  task automatic ctl(input logic ce_n, input logic oe_n, input logic we_n);
    @(posedge clock_in);
    pins_out.ce_n <= ce_n;
    pins_out.oe_n <= oe_n | ~we_n;
    pins_out.we_n <= we_n;
  endtask

  // address and strobe level
  task automatic put_addr(input fbadp_addr_t a, input logic strobe_n);
    @(posedge clock_in);
    pins_out.addr <= a;
    pins_out.address_strobe_n <= strobe_n;
  endtask

  // one bus clock pulse; it stands still otherwise
  task automatic clk_edge();
    @(posedge clock_in);
    pins_out.bus_clk <= 1'b1;
    @(posedge clock_in);
    pins_out.bus_clk <= 1'b0;
  endtask

  // one write; released data shows the inverse of the word
  task automatic wr(input fbadp_addr_t a, input fbadp_data_t d,
                    input logic ce_n);
    @(posedge clock_in);
    pins_out.addr <= a;
    pins_out.dq <= d;
    pins_out.ce_n <= ce_n;
    pins_out.oe_n <= 1'b1;
    pins_out.we_n <= 1'b0;
    hold(3);
    pins_out.we_n <= 1'b1;
    hold(3);
    pins_out.ce_n <= 1'b1;
    pins_out.dq <= ~d;
  endtask
endmodule // fbadp_host_model

// ### bench/fbadp_port_tb_top.sv
// fbadp_port_tb_top: self-checking bench of the flash bus port.
// assumes the host model drives the pins and the bench the core side.
`timescale 1ns/1ns
module fbadp_port_tb_top;
  import fbadp_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clock_in, rst_n_in, sync_mode_in, data_valid_in, pol;
  fbadp_pins_s pins;
  fbadp_read_mode_e read_mode_in;
  fbadp_data_t src [4];
  fbadp_data_t dq_out, write_data_out, d0;
  fbadp_addr_t read_addr_out, write_addr_out, a0;
  logic dq_oe_out, wait_out, wait_oe_out, die_upper_out, die_active_out;
  logic standby_out, write_strobe_out;
  int mismatches, n_compared, cycles, n_wr, n0;

  fbadp_host_model i_host (.clock_in(clock_in), .pins_out(pins));
  fbadp_port i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .pins_in(pins), .sync_mode_in(sync_mode_in),
    .read_mode_in(read_mode_in), .array_data_in(src[0]),
    .status_in(src[1]), .protection_in(src[2]),
    .read_config_register_in(src[3]), .data_valid_in(data_valid_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .wait_out(wait_out),
    .wait_oe_out(wait_oe_out), .read_addr_out(read_addr_out),
    .die_upper_out(die_upper_out), .die_active_out(die_active_out),
    .standby_out(standby_out), .write_strobe_out(write_strobe_out),
    .write_addr_out(write_addr_out), .write_data_out(write_data_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock, timeout counter and write pulse counter
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (write_strobe_out === 1'b1) n_wr++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  // wait level: asserted only for sync reads without valid data
  function automatic logic exp_wait(input logic s, input logic v,
                                    input logic p);
    return (s && !v) ? p : !p;
  endfunction

  task automatic settle(input int n);
    i_host.hold(n);
    #1;
  endtask

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error %0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    sync_mode_in = 1'b0;
    data_valid_in = 1'b0;
    read_mode_in = FBADP_READ_ARRAY;
    foreach (src[k]) src[k] = '0;
    void'($urandom(32'h21a5f98e));
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    settle(3);
    check(standby_out === 1'b1 && dq_oe_out === 1'b0, "idle");
    // every read source, then float by each enable
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock_in);
      read_mode_in <= fbadp_read_mode_e'(m);
      foreach (src[k]) src[k] <= fbadp_data_t'($urandom);
      i_host.ctl(1'b0, 1'b0, 1'b1);
      settle(5);
      check(dq_oe_out === 1'b1 && dq_out === src[m], "read word");
      check(die_active_out === 1'b1 && standby_out === 1'b0, "act");
      i_host.ctl(1'b0, 1'b1, 1'b1);
      settle(5);
      check(dq_oe_out === 1'b0 && wait_oe_out === 1'b0, "oe");
      i_host.ctl(1'b1, 1'b0, 1'b1);
      settle(5);
      check(wait_oe_out === 1'b0 && standby_out === 1'b1, "ce");
      check(dq_oe_out === 1'b0, "ce data");
    end
    // wait level over mode, valid and polarity
    for (int w = 0; w < 8; w++)
    begin
      d0 = fbadp_data_t'($urandom);
      d0[WAIT_POL_BIT] = w[0];
      @(posedge clock_in);
      sync_mode_in <= w[2];
      data_valid_in <= w[1];
      src[3] <= d0;
      i_host.ctl(1'b0, 1'b0, 1'b1);
      settle(5);
      pol = exp_wait(w[2], w[1], w[0]);
      check(wait_oe_out === 1'b1 && wait_out === pol, "wait");
      i_host.ctl(1'b1, 1'b1, 1'b1);
    end
    // async flow with bus clock ignored, word step, die select
    @(posedge clock_in);
    sync_mode_in <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      a0 = (i == 2) ? fbadp_addr_t'(1) : fbadp_addr_t'($urandom);
      if (i == 3) a0 = '1;
      a0[DIE_SEL_BIT] = i[0];
      i_host.put_addr(a0, 1'b0);
      i_host.clk_edge();
      settle(4);
      check(read_addr_out === a0 && die_upper_out === i[0], "flow");
    end
    i_host.put_addr(a0, 1'b1);
    i_host.put_addr(~a0, 1'b1);
    settle(5);
    check(read_addr_out === a0, "strobe latch");
    // sync: first bus clock edge captures, later ones ignored
    @(posedge clock_in);
    sync_mode_in <= 1'b1;
    a0 = fbadp_addr_t'($urandom);
    i_host.put_addr(a0, 1'b0);
    i_host.clk_edge();
    i_host.put_addr(~a0, 1'b0);
    i_host.clk_edge();
    settle(4);
    check(read_addr_out === a0, "sync clock capture");
    // sync: strobe rise before any bus clock edge, on a fresh address
    i_host.put_addr(a0, 1'b1);
    a0 = ~a0;
    i_host.put_addr(a0, 1'b0);
    i_host.hold(2);
    i_host.put_addr(a0, 1'b1);
    i_host.put_addr(~a0, 1'b1);
    settle(5);
    check(read_addr_out === a0, "sync strobe capture");
    // back-to-back writes, last one with chip deselected
    for (int i = 0; i < 3; i++)
    begin
      a0 = fbadp_addr_t'($urandom);
      d0 = fbadp_data_t'($urandom);
      n0 = n_wr;
      i_host.wr(a0, d0, i == 2);
      settle(4);
      check(n_wr === n0 + ((i == 2) ? 0 : 1), "write pulses");
      if (i < 2)
        check(write_addr_out === a0 && write_data_out === d0, "word");
    end
    final_report();
  end
endmodule // fbadp_port_tb_top
